// File: rtl/cmla_pkg.sv
package cmla_pkg;
    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int NCELL = 8;
    localparam int NSIG = 18;
    localparam int NPT = 64;
    localparam int NPTC = 8;
    localparam int NFW = 128;
    localparam int FW_W = 18;
    localparam int SIG_FB = 8;
    localparam int SIG_CK = 16;
    localparam int SIG_OE = 17;

    // ------------------------------------------------------------
    // register map, byte addresses within the slave window
    // ------------------------------------------------------------
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_STAT = 12'h004;
    localparam logic [11:0] A_PTEN_LO = 12'h008;
    localparam logic [11:0] A_PTEN_HI = 12'h00c;
    localparam logic [11:0] A_SIG_LO = 12'h010;
    localparam logic [11:0] A_SIG_HI = 12'h014;
    localparam logic [11:0] A_SECURE = 12'h018;
    localparam logic [11:0] A_FUSE = 12'h100;
    localparam logic [11:0] A_FUSE_END = 12'h2fc;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_LSB = 0;
    localparam int REGSEL_LSB = 8;
    localparam int OUTEN_LSB = 16;
    localparam int POL_LSB = 24;
    localparam int ST_OUT_LSB = 0;
    localparam int ST_DRV_LSB = 8;
    localparam int ST_REG_LSB = 16;
    localparam int ST_MODE_LSB = 24;
    localparam int ST_SEC_BIT = 26;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [63:0] PTEN_RST = 64'h0;
    localparam logic [63:0] SIG_RST = 64'h0;
    localparam logic [FW_W-1:0] FUSE_RST = 18'h0;
    localparam logic [1:0] RD_WAIT = 2'h2;

    typedef enum logic [1:0] {
        CMLA_REG = 2'h0,
        CMLA_CPLX = 2'h1,
        CMLA_SIMP = 2'h3
    } cmla_mode_t;
endpackage : cmla_pkg

// File: rtl/cmla_fuse_mem.sv
`timescale 1ns/1ps
module cmla_fuse_mem (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic we,
    input wire logic [6:0] waddr,
    input wire logic [cmla_pkg::FW_W-1:0] wdata,
    input wire logic [6:0] raddr,
    output logic [cmla_pkg::FW_W-1:0] rdata,
    output logic [cmla_pkg::NFW*cmla_pkg::FW_W-1:0] all_q
);
    import cmla_pkg::*;

    logic [FW_W-1:0] mem_q [NFW];
    logic [FW_W-1:0] mem_d [NFW];
    logic [FW_W-1:0] rdata_q;
    logic [FW_W-1:0] rdata_d;

    // ------------------------------------------------------------
    // fuse words: one write port, one registered read port
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NFW; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (we) begin
            mem_d[waddr] = wdata;
        end
        rdata_d = mem_q[raddr];
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < NFW; i++) begin
                mem_q[i] <= FUSE_RST;
            end
            rdata_q <= FUSE_RST;
        end else if (ce) begin
            mem_q <= mem_d;
            rdata_q <= rdata_d;
        end
    end

    // flat view for the product-term array
    always_comb begin
        for (int i = 0; i < NFW; i++) begin
            all_q[i*FW_W +: FW_W] = mem_q[i];
        end
    end

    assign rdata = rdata_q;
endmodule : cmla_fuse_mem

// File: rtl/cmla_array.sv
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
// Operation
// - eight macrocells, each registered out, comb I/O, comb out or input.
// - exactly one of registered, complex or simple mode is active.
// - registered mode uses the clock pin and low-active enable pin.
// - registered mode keeps clock and enable pins out of the array.
// - complex mode feeds clock and enable pins into the array.
// - complex mode feeds the six inner macrocell pins back.
// - complex mode gives outer macrocells no pin feedback.
// - complex mode ORs seven terms, one more term drives the enable.
// - simple mode ORs eight terms and has no enable term.
// - simple mode drives the two center macrocells always.
// - simple mode other cells are inputs or fed-back outputs.
// - a disabled product term never adds to its sum.
// - with the security fuse set, fuse readout returns zero.
// - the eight-byte signature reads back regardless of security.
module cmla_array (
    input wire logic clk,
    input wire logic ce,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic clk_pin,
    input wire logic oe_pin_n,
    input wire logic [7:0] ded_pin,
    input wire logic [cmla_pkg::NCELL-1:0] io_in,
    output logic [cmla_pkg::NCELL-1:0] io_out,
    output logic [cmla_pkg::NCELL-1:0] io_oe_n
);
    import cmla_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic fuse_hit(input logic [11:0] a);
        fuse_hit = (a >= A_FUSE) && (a <= A_FUSE_END);
    endfunction : fuse_hit

    function automatic logic [6:0] fuse_idx(input logic [11:0] a);
        logic [7:0] w;
        w = a[9:2] - 8'h40;
        fuse_idx = w[6:0];
    endfunction : fuse_idx

    function automatic logic pt_eval(input logic [NSIG-1:0] tm,
            input logic [NSIG-1:0] cm, input logic [NSIG-1:0] s,
            input logic [NSIG-1:0] av);
        pt_eval = &(~(tm & av) | s) & &(~(cm & av) | ~s);
    endfunction : pt_eval

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [NSIG-1:0] s1_q, s2_q, s3_q, flt_q, flt_d;
    logic ck_prev_q;
    logic [31:0] ctrl_q, ctrl_d;
    logic [63:0] pten_q, pten_d, sig_q, sig_d;
    logic sec_q, sec_d;
    logic [11:0] addr_q, addr_d;
    logic hit_q, hit_d, wr_q, wr_d;
    logic [1:0] rd_cnt_q, rd_cnt_d;
    logic rdy_q, rdy_d;
    logic [31:0] rdata_q, rdata_d;
    logic [NCELL-1:0] reg_q, reg_d, out_q, out_d, oen_q, oen_d;
    logic [FW_W-1:0] mem_rdata;
    logic [NFW*FW_W-1:0] fuses;
    logic mem_we, acc;
    cmla_mode_t mode_q;
    logic [NCELL-1:0] regsel, outen, pol, sum, oe_term;
    logic [NSIG-1:0] sigv, avail;
    logic [NPT-1:0] pt;
    logic ck_rise;

    assign mode_q = cmla_mode_t'(ctrl_q[MODE_LSB +: 2]);
    assign regsel = ctrl_q[REGSEL_LSB +: NCELL];
    assign outen = ctrl_q[OUTEN_LSB +: NCELL];
    assign pol = ctrl_q[POL_LSB +: NCELL];
    assign ck_rise = flt_q[SIG_CK] & ~ck_prev_q;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // a change counts once the second and third stages agree
    always_comb begin
        flt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & flt_q);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            flt_q <= '0;
            ck_prev_q <= 1'b0;
        end else if (ce) begin
            s1_q <= {oe_pin_n, clk_pin, io_in, ded_pin};
            s2_q <= s1_q;
            s3_q <= s2_q;
            flt_q <= flt_d;
            ck_prev_q <= flt_q[SIG_CK];
        end
    end

    // ------------------------------------------------------------
    // AND array and macrocells
    // ------------------------------------------------------------
    // signal selection per mode
    always_comb begin
        sigv = flt_q;
        for (int c = 0; c < NCELL; c++) begin
            if (mode_q == CMLA_REG && regsel[c]) begin
                sigv[SIG_FB+c] = reg_q[c];
            end
        end
        case (mode_q)
            CMLA_CPLX: avail = {2'b11, 1'b0, 6'h3f, 1'b0, 8'hff};
            CMLA_SIMP: avail = {2'b11, 3'h7, 2'h0, 3'h7, 8'hff};
            default: avail = {2'b00, 16'hffff};
        endcase
    end

    // product terms, gated by their enable bits
    always_comb begin
        for (int k = 0; k < NPT; k++) begin
            pt[k] = pten_q[k] & pt_eval(fuses[(2*k)*FW_W +: FW_W],
                fuses[(2*k+1)*FW_W +: FW_W], sigv, avail);
        end
    end

    // sums, register and pin drive for each macrocell
    always_comb begin
        for (int c = 0; c < NCELL; c++) begin
            oe_term[c] = pt[c*NPTC];
            if (mode_q == CMLA_SIMP || (mode_q == CMLA_REG && regsel[c])) begin
                sum[c] = (|pt[c*NPTC +: NPTC]) ^ pol[c];
            end else begin
                sum[c] = (|pt[c*NPTC+1 +: NPTC-1]) ^ pol[c];
            end
            reg_d[c] = reg_q[c];
            out_d[c] = sum[c];
            oen_d[c] = ~oe_term[c];
            if (mode_q == CMLA_REG && regsel[c]) begin
                if (ck_rise) begin
                    reg_d[c] = sum[c];
                end
                out_d[c] = reg_q[c];
                oen_d[c] = flt_q[SIG_OE];
            end else if (mode_q == CMLA_SIMP) begin
                if (c == 3 || c == 4) begin
                    oen_d[c] = 1'b0;
                end else begin
                    oen_d[c] = ~outen[c];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_q <= '0;
            out_q <= '0;
            oen_q <= '1;
        end else if (ce) begin
            reg_q <= reg_d;
            out_q <= out_d;
            oen_q <= oen_d;
        end
    end

    assign io_out = out_q;
    assign io_oe_n = oen_q;

    // ------------------------------------------------------------
    // AHB-Lite slave and configuration registers
    // ------------------------------------------------------------
    assign acc = hsel & hready & htrans[1];
    assign mem_we = wr_q && hit_q && fuse_hit(addr_q);

    // address phase capture, write data phase, read wait states
    always_comb begin
        addr_d = addr_q;
        hit_d = hit_q;
        wr_d = 1'b0;
        rd_cnt_d = rd_cnt_q;
        rdy_d = rdy_q;
        rdata_d = rdata_q;
        ctrl_d = ctrl_q;
        pten_d = pten_q;
        sig_d = sig_q;
        sec_d = sec_q;
        if (wr_q && hit_q) begin
            if (addr_q == A_CTRL) begin
                ctrl_d = hwdata;
                if (hwdata[MODE_LSB +: 2] == 2'h2) begin
                    ctrl_d[MODE_LSB +: 2] = ctrl_q[MODE_LSB +: 2];
                end
            end else if (addr_q == A_PTEN_LO) begin
                pten_d[31:0] = hwdata;
            end else if (addr_q == A_PTEN_HI) begin
                pten_d[63:32] = hwdata;
            end else if (addr_q == A_SIG_LO) begin
                sig_d[31:0] = hwdata;
            end else if (addr_q == A_SIG_HI) begin
                sig_d[63:32] = hwdata;
            end else if (addr_q == A_SECURE) begin
                sec_d = sec_q | hwdata[0];
            end
        end
        if (rd_cnt_q == 2'h1) begin
            rdata_d = 32'h0;
            rdy_d = 1'b1;
            if (!hit_q) begin
                rdata_d = 32'h0;
            end else if (addr_q == A_CTRL) begin
                rdata_d = ctrl_q;
            end else if (addr_q == A_STAT) begin
                rdata_d[ST_OUT_LSB +: NCELL] = out_q;
                rdata_d[ST_DRV_LSB +: NCELL] = ~oen_q;
                rdata_d[ST_REG_LSB +: NCELL] = reg_q;
                rdata_d[ST_MODE_LSB +: 2] = mode_q;
                rdata_d[ST_SEC_BIT] = sec_q;
            end else if (addr_q == A_PTEN_LO) begin
                rdata_d = pten_q[31:0];
            end else if (addr_q == A_PTEN_HI) begin
                rdata_d = pten_q[63:32];
            end else if (addr_q == A_SIG_LO) begin
                rdata_d = sig_q[31:0];
            end else if (addr_q == A_SIG_HI) begin
                rdata_d = sig_q[63:32];
            end else if (addr_q == A_SECURE) begin
                rdata_d[0] = sec_q;
            end else if (fuse_hit(addr_q) && !sec_q) begin
                rdata_d[FW_W-1:0] = mem_rdata;
            end
        end
        if (rd_cnt_q != 2'h0) begin
            rd_cnt_d = rd_cnt_q - 2'h1;
        end
        if (acc) begin
            addr_d = haddr[11:0];
            hit_d = (haddr[31:12] == 20'h0) && (hsize == 3'h2);
            wr_d = hwrite;
            if (!hwrite) begin
                rd_cnt_d = RD_WAIT;
                rdy_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            addr_q <= 12'h0;
            hit_q <= 1'b0;
            wr_q <= 1'b0;
            rd_cnt_q <= 2'h0;
            rdy_q <= 1'b1;
            rdata_q <= 32'h0;
            ctrl_q <= CTRL_RST;
            pten_q <= PTEN_RST;
            sig_q <= SIG_RST;
            sec_q <= 1'b0;
        end else if (ce) begin
            addr_q <= addr_d;
            hit_q <= hit_d;
            wr_q <= wr_d;
            rd_cnt_q <= rd_cnt_d;
            rdy_q <= rdy_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
            pten_q <= pten_d;
            sig_q <= sig_d;
            sec_q <= sec_d;
        end
    end

    assign hreadyout = rdy_q;
    assign hrdata = rdata_q;
    assign hresp = 1'b0;

    cmla_fuse_mem u_fuse (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .we(mem_we),
        .waddr(fuse_idx(addr_q)),
        .wdata(hwdata[FW_W-1:0]),
        .raddr(fuse_idx(addr_q)),
        .rdata(mem_rdata),
        .all_q(fuses)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_mode_legal: assert property (ctrl_q[MODE_LSB +: 2] != 2'h2)
        else $error("illegal architecture mode");
    a_reg_pins_out: assert property ((mode_q == CMLA_REG) |->
        avail[SIG_OE:SIG_CK] == 2'b00)
        else $error("clock or enable pin reached array");
    a_pins_as_in: assert property ((mode_q != CMLA_REG) |->
        avail[SIG_OE:SIG_CK] == 2'b11)
        else $error("clock or enable pin not offered");
    a_cplx_fb_mask: assert property ((mode_q == CMLA_CPLX) |->
        avail[SIG_FB +: NCELL] == 8'h7e)
        else $error("complex feedback set wrong");
    a_reg_capture: assert property ((ce && ck_rise &&
        mode_q == CMLA_REG) |=> ((reg_q ^ $past(sum)) & $past(regsel)) == 0)
        else $error("register missed clock rise");
    a_reg_hold: assert property ((ce && !ck_rise) |=>
        reg_q == $past(reg_q))
        else $error("register changed without clock rise");
    a_reg_oe_pin: assert property ((ce && mode_q == CMLA_REG) |=>
        ((io_oe_n ^ {NCELL{$past(flt_q[SIG_OE])}}) & $past(regsel)) == 0)
        else $error("registered enable not from pin");
    a_cplx_oe_term: assert property ((ce && mode_q == CMLA_CPLX) |=>
        io_oe_n == ~$past(oe_term))
        else $error("complex enable not from its term");
    a_simp_center: assert property ((ce && mode_q == CMLA_SIMP) |=>
        io_oe_n[4:3] == 2'b00)
        else $error("center cell not driven");
    a_pt_off_quiet: assert property ((ce && pten_q == 64'h0 &&
        mode_q == CMLA_SIMP) |=> io_out == $past(pol))
        else $error("disabled term reached a sum");
    a_sec_no_fuse: assert property ((ce && rd_cnt_q == 2'h1 && sec_q &&
        fuse_hit(addr_q)) |=> hrdata == 32'h0)
        else $error("fuse read while secured");
    a_sig_readout: assert property ((ce && rd_cnt_q == 2'h1 && hit_q &&
        addr_q == A_SIG_LO) |=> hrdata == $past(sig_q[31:0]))
        else $error("signature readout wrong");

    c_reg_clock: cover property (ck_rise && mode_q == CMLA_REG);
    c_cplx_drive: cover property (mode_q == CMLA_CPLX && io_oe_n != 8'hff);
    c_sec_read: cover property (sec_q && rd_cnt_q == 2'h1 && fuse_hit(addr_q));
endmodule : cmla_array

// File: verif/cmla_board.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// board model: dedicated pin drivers and shared macrocell pins
// ------------------------------------------------------------
module cmla_board (
    input wire logic [7:0] set_ded,
    input wire logic set_ck,
    input wire logic set_oe_n,
    input wire logic [7:0] set_io,
    input wire logic [7:0] io_out,
    input wire logic [7:0] io_oe_n,
    output logic [7:0] ded_pin,
    output logic clk_pin,
    output logic oe_pin_n,
    output logic [7:0] io_in
);
    // a shared pin shows the cell while it drives, else the board level
    always_comb begin
        ded_pin = set_ded;
        clk_pin = set_ck;
        oe_pin_n = set_oe_n;
        io_in = (io_out & ~io_oe_n) | (set_io & io_oe_n);
    end
endmodule : cmla_board

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import cmla_pkg::*;
    logic clk, ce, reset_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic set_ck, set_oe_n, clk_pin, oe_pin_n;
    logic [7:0] set_ded, set_io, ded_pin, io_in, io_out, io_oe_n;
    int n_errors, samples_checked;

    assign hready = hreadyout;

    cmla_array dut (.clk(clk), .ce(ce), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .clk_pin(clk_pin),
        .oe_pin_n(oe_pin_n), .ded_pin(ded_pin), .io_in(io_in),
        .io_out(io_out), .io_oe_n(io_oe_n));

    cmla_board board (.set_ded(set_ded), .set_ck(set_ck),
        .set_oe_n(set_oe_n), .set_io(set_io), .io_out(io_out),
        .io_oe_n(io_oe_n), .ded_pin(ded_pin), .clk_pin(clk_pin),
        .oe_pin_n(oe_pin_n), .io_in(io_in));

    // ------------------------------------------------------------
    // clock
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t ns %s: seen %h expected %h", $time, what,
                     seen, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", samples_checked,
                 n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic done(input string s);
        $display("test %s done, mismatches so far %0d", s, n_errors);
    endtask : done

    // ------------------------------------------------------------
    // bus master: address phase, then data phase, each until hready
    // ------------------------------------------------------------
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 40);
        if (hready !== 1'b1) begin
            n_errors++;
            $display("[FAIL] %0t ns bus wait ran out", $time);
            report_and_stop();
        end
    endtask : wait_rdy

    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        haddr <= {20'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hffff_ffff);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x & m, e, "register read");
        chk(hresp, 1'b0, "bus response");
    endtask : rd

    // true and complement masks of one product term
    task automatic fuse(input int k, input logic [17:0] t,
                        input logic [17:0] c);
        wr(A_FUSE + 12'(k * 8), {14'h0, t});
        wr(A_FUSE + 12'(k * 8 + 4), {14'h0, c});
    endtask : fuse

    // pin to output takes five edges, leave some margin
    task automatic settle();
        repeat (8) @(posedge clk);
    endtask : settle

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        n_errors = 0;
        samples_checked = 0;
        ce = 1'b1;
        reset_n = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        set_ded = 8'h00;
        set_ck = 1'b0;
        set_oe_n = 1'b1;
        set_io = 8'h00;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        // reset values, unmapped offset, signature
        rd(A_CTRL, CTRL_RST);
        rd(A_STAT, 32'h0);
        rd(A_PTEN_HI, 32'h0);
        rd(12'h01c, 32'h0);
        chk(io_oe_n, 8'hff, "drivers after reset");
        wr(A_SIG_LO, 32'h1234_5678);
        wr(A_SIG_HI, 32'h9abc_def0);
        rd(A_SIG_LO, 32'h1234_5678);
        rd(A_SIG_HI, 32'h9abc_def0);
        done("reset and signature");
        // simple mode: true, complement and clock pin literals
        fuse(0, 18'h1, 18'h0);
        fuse(8, 18'h0, 18'h2);
        fuse(16, 18'h1_0000, 18'h0);
        wr(A_PTEN_LO, 32'h0001_0101);
        wr(A_CTRL, 32'h0007_0003);
        settle();
        chk(io_out, 8'h02, "simple outputs");
        chk(io_oe_n, 8'he0, "simple drivers");
        set_ded <= 8'h03;
        set_ck <= 1'b1;
        settle();
        chk(io_out, 8'h05, "simple inputs");
        set_ded <= 8'h00;
        wr(A_PTEN_LO, 32'h0001_0181);
        settle();
        chk(io_out, 8'h07, "eighth term");
        wr(A_CTRL, 32'h0107_0003);
        settle();
        chk(io_out, 8'h06, "inverted cell");
        // clock enable low freezes the pin path, release lets it through
        ce <= 1'b0;
        set_ded <= 8'h02;
        settle();
        chk(io_out, 8'h06, "frozen while disabled");
        ce <= 1'b1;
        settle();
        chk(io_out, 8'h04, "complement after enable");
        set_ded <= 8'h00;
        done("simple mode");
        // complex mode: enable terms, pin feedback, outer cells
        set_ck <= 1'b0;
        set_io <= 8'h04;
        fuse(41, 18'h2_0000, 18'h0);
        fuse(49, 18'h0_0400, 18'h0);
        fuse(9, 18'h0_0100, 18'h0);
        wr(A_PTEN_LO, 32'h0000_0300);
        wr(A_PTEN_HI, 32'h0103_0300);
        wr(A_CTRL, 32'h0000_0001);
        wr(A_CTRL, 32'h0000_0002);
        rd(A_CTRL, 32'h0000_0001);
        settle();
        chk(io_out, 8'h62, "complex outputs");
        chk(io_oe_n, 8'h1d, "complex drivers");
        set_oe_n <= 1'b0;
        set_io <= 8'h00;
        set_ded <= 8'h02;
        settle();
        chk(io_out & 8'h60, 8'h00, "complex follow");
        chk(io_oe_n, 8'h1f, "enable term off");
        done("complex mode");
        // registered mode: common clock and common enable
        set_ded <= 8'h08;
        fuse(24, 18'h0_0008, 18'h0);
        fuse(33, 18'h1_0000, 18'h0);
        wr(A_PTEN_LO, 32'h0100_0000);
        wr(A_PTEN_HI, 32'h0000_0003);
        wr(A_CTRL, 32'h0000_0800);
        settle();
        chk(io_out & 8'h18, 8'h10, "before clock");
        chk(io_oe_n, 8'he7, "registered drivers");
        set_ck <= 1'b1;
        settle();
        set_ck <= 1'b0;
        set_ded <= 8'h00;
        settle();
        chk(io_out & 8'h18, 8'h18, "captured value");
        set_oe_n <= 1'b1;
        settle();
        chk(io_oe_n & 8'h18, 8'h08, "common enable off");
        set_ck <= 1'b1;
        settle();
        chk(io_out & 8'h08, 8'h00, "second capture");
        done("registered mode");
        // security bit hides the fuses, not the signature
        rd(A_FUSE + 12'h0c0, 32'h0000_0008);
        wr(A_SECURE, 32'h0000_0001);
        rd(A_FUSE + 12'h0c0, 32'h0);
        rd(A_STAT, 32'h0400_0000, 32'h0700_0000);
        rd(A_SIG_HI, 32'h9abc_def0);
        done("security");
        report_and_stop();
    end
endmodule : tb_top
